//--- rtl/cdm_pkg.sv
// Purpose: Shared constants and types for the data-move and word-op core.
// Assumes: One clock, asynchronous active-low reset, plain register port.
// Notes:   Program and data share one on-chip byte array inside the core.
package cdm_pkg;

  // Byte array address width; addresses wrap at this many bits.
  localparam int MEM_AW = 10;

  // Register port byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC     = 8'h08;
  localparam logic [7:0] REG_ACC    = 8'h0c;
  localparam logic [7:0] REG_X      = 8'h10;
  localparam logic [7:0] REG_Y      = 8'h14;
  localparam logic [7:0] REG_SP     = 8'h18;
  localparam logic [7:0] REG_PSW    = 8'h1c;
  localparam logic [7:0] REG_MADDR  = 8'h20;
  localparam logic [7:0] REG_MDATA  = 8'h24;

  localparam int CTRL_RUN_BIT  = 0;
  localparam int STAT_HALT_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // Program status word bit positions.
  localparam int PSW_N = 7;
  localparam int PSW_V = 6;
  localparam int PSW_G = 5;
  localparam int PSW_H = 3;
  localparam int PSW_Z = 1;
  localparam int PSW_C = 0;

  localparam logic [15:0] RST_PC  = 16'h0000;
  localparam logic [7:0]  RST_SP  = 8'hff;
  localparam logic [7:0]  RST_PSW = 8'h00;

  typedef enum logic [3:0] {
    AM_NONE, AM_IMM, AM_DP, AM_DPX, AM_DPY, AM_ABS, AM_ABSY,
    AM_IDX, AM_IDY, AM_XIND, AM_XINC
  } cdm_mode_t;

  typedef enum logic [4:0] {
    OP_LDA, OP_LDX, OP_LDY, OP_STA, OP_STX, OP_STY, OP_STM,
    OP_TAX, OP_TAY, OP_COPY_STACKPTR_TO_X, OP_TXA, OP_COPY_X_TO_STACKPTR, OP_TYA,
    OP_XAX, OP_XAY, OP_XMA, OP_XYX,
    OP_WORD_ADD, OP_WORD_SUBTRACT, OP_WORD_COMPARE, OP_WORD_DECREMENT, OP_WORD_INCREMENT, OP_WORD_LOAD_PAIR, OP_WORD_STORE_PAIR
  } cdm_op_t;

  typedef enum logic [3:0] {
    PH_FETCH, PH_OPND1, PH_OPND2, PH_PTRLO, PH_PTRHI,
    PH_READ1, PH_READ2, PH_WRITE1, PH_WRITE2, PH_EXEC, PH_PAD
  } cdm_phase_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] bytes;
    logic [3:0] cycles;
    cdm_mode_t  mode;
    cdm_op_t    op;
  } cdm_dec_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cdm_reg_req_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } cdm_mem_wr_t;

  typedef struct packed {
    cdm_phase_t  phase;
    logic [3:0]  cnt;
    logic [15:0] pc;
    logic [7:0]  a;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [7:0]  sp;
    logic [7:0]  psw;
    cdm_dec_t    dec;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [15:0] ea;
    logic [7:0]  tmp;
    logic [15:0] wres;
    logic        run;
    logic        halted;
    logic [15:0] maddr;
    logic [15:0] rdata;
  } cdm_state_t;

endpackage : cdm_pkg

//--- rtl/cdm_core.sv
// Purpose: Sequencer for loads, stores, transfers, exchanges and word ops.
// Assumes: Program and data bytes live in the local array, read in zero wait.
// Notes:   Each instruction is padded to its fixed cycle count after its work.
`timescale 1ns/1ps

// Notes on behaviour
// - Load A via X then bump X, 4 cycles.
// - Store immediate to direct page, 3 bytes 5 cycles.
// - Store A, flags kept; dp 4, indirect 7.
// - Store A via X then bump X, 4 cycles.
// - Store X by dp, dp+Y, abs; flags kept.
// - Store Y by dp, dp+X, abs; flags kept.
// - Copy A into X, 2 cycles, N Z.
// - Copy A into Y, 2 cycles, N Z.
// - Copy between stack pointer and X, N Z.
// - Copy X or Y into A, N Z.
// - Swap A with X or Y, 4 cycles, flags kept.
// - Swap A with memory, set N Z, 5/6/5.
// - Swap X with Y, 4 cycles, flags kept.
// - Word add to Y:A, N V H Z C, 5 cycles.
// - Word subtract from Y:A, N V H Z C, 5 cycles.
// - Word compare sets N Z C only, 4 cycles.
// - Word decrement memory pair, N Z, 6 cycles.
// - Word increment memory pair, N Z, 6 cycles.
// - Word load dp into A, next into Y.
// - Word store A then Y, flags kept.
// - Y loads index by X, X loads by Y.
module cdm_core
  import cdm_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire cdm_reg_req_t reg_req,
  output logic [15:0]       reg_rdata,
  output logic              core_halted
);

  cdm_state_t  s;
  cdm_state_t  next_s;
  cdm_mem_wr_t mem_wr;
  logic [7:0]  mem [0:(1 << MEM_AW) - 1];
  logic [15:0] rd_addr;
  logic [7:0]  rd_byte;
  logic [7:0]  host_byte;

  function automatic cdm_dec_t cdm_decode(input logic [7:0] opc);
    cdm_dec_t d;
    d = '0;
    case (opc)
      8'hc4: d = '{1'b1, 2'd2, 4'd2, AM_IMM,  OP_LDA};
      8'hc5: d = '{1'b1, 2'd2, 4'd3, AM_DP,   OP_LDA};
      8'hc6: d = '{1'b1, 2'd2, 4'd4, AM_DPX,  OP_LDA};
      8'hc7: d = '{1'b1, 2'd3, 4'd4, AM_ABS,  OP_LDA};
      8'hd5: d = '{1'b1, 2'd3, 4'd5, AM_ABSY, OP_LDA};
      8'hd6: d = '{1'b1, 2'd2, 4'd6, AM_IDX,  OP_LDA};
      8'hd7: d = '{1'b1, 2'd2, 4'd6, AM_IDY,  OP_LDA};
      8'hd4: d = '{1'b1, 2'd1, 4'd3, AM_XIND, OP_LDA};
      8'hdb: d = '{1'b1, 2'd1, 4'd4, AM_XINC, OP_LDA};
      8'he4: d = '{1'b1, 2'd3, 4'd5, AM_DP,   OP_STM};
      8'h1e: d = '{1'b1, 2'd2, 4'd2, AM_IMM,  OP_LDX};
      8'hcc: d = '{1'b1, 2'd2, 4'd3, AM_DP,   OP_LDX};
      8'hcd: d = '{1'b1, 2'd2, 4'd4, AM_DPY,  OP_LDX};
      8'hdc: d = '{1'b1, 2'd3, 4'd4, AM_ABS,  OP_LDX};
      8'h3e: d = '{1'b1, 2'd2, 4'd2, AM_IMM,  OP_LDY};
      8'hc9: d = '{1'b1, 2'd2, 4'd3, AM_DP,   OP_LDY};
      8'hd9: d = '{1'b1, 2'd2, 4'd4, AM_DPX,  OP_LDY};
      8'hd8: d = '{1'b1, 2'd3, 4'd4, AM_ABS,  OP_LDY};
      8'he5: d = '{1'b1, 2'd2, 4'd4, AM_DP,   OP_STA};
      8'he6: d = '{1'b1, 2'd2, 4'd5, AM_DPX,  OP_STA};
      8'he7: d = '{1'b1, 2'd3, 4'd5, AM_ABS,  OP_STA};
      8'hf5: d = '{1'b1, 2'd3, 4'd6, AM_ABSY, OP_STA};
      8'hf6: d = '{1'b1, 2'd2, 4'd7, AM_IDX,  OP_STA};
      8'hf7: d = '{1'b1, 2'd2, 4'd7, AM_IDY,  OP_STA};
      8'hf4: d = '{1'b1, 2'd1, 4'd4, AM_XIND, OP_STA};
      8'hfb: d = '{1'b1, 2'd1, 4'd4, AM_XINC, OP_STA};
      8'hec: d = '{1'b1, 2'd2, 4'd4, AM_DP,   OP_STX};
      8'hed: d = '{1'b1, 2'd2, 4'd5, AM_DPY,  OP_STX};
      8'hfc: d = '{1'b1, 2'd3, 4'd5, AM_ABS,  OP_STX};
      8'he9: d = '{1'b1, 2'd2, 4'd4, AM_DP,   OP_STY};
      8'hf9: d = '{1'b1, 2'd2, 4'd5, AM_DPX,  OP_STY};
      8'hf8: d = '{1'b1, 2'd3, 4'd5, AM_ABS,  OP_STY};
      8'he8: d = '{1'b1, 2'd1, 4'd2, AM_NONE, OP_TAX};
      8'h9f: d = '{1'b1, 2'd1, 4'd2, AM_NONE, OP_TAY};
      8'hae: d = '{1'b1, 2'd1, 4'd2, AM_NONE, OP_COPY_STACKPTR_TO_X};
      8'hc8: d = '{1'b1, 2'd1, 4'd2, AM_NONE, OP_TXA};
      8'h8e: d = '{1'b1, 2'd1, 4'd2, AM_NONE, OP_COPY_X_TO_STACKPTR};
      8'hbf: d = '{1'b1, 2'd1, 4'd2, AM_NONE, OP_TYA};
      8'hee: d = '{1'b1, 2'd1, 4'd4, AM_NONE, OP_XAX};
      8'hde: d = '{1'b1, 2'd1, 4'd4, AM_NONE, OP_XAY};
      8'hbc: d = '{1'b1, 2'd2, 4'd5, AM_DP,   OP_XMA};
      8'had: d = '{1'b1, 2'd2, 4'd6, AM_DPX,  OP_XMA};
      8'hbb: d = '{1'b1, 2'd1, 4'd5, AM_XIND, OP_XMA};
      8'hfe: d = '{1'b1, 2'd1, 4'd4, AM_NONE, OP_XYX};
      8'h1d: d = '{1'b1, 2'd2, 4'd5, AM_DP,   OP_WORD_ADD};
      8'h3d: d = '{1'b1, 2'd2, 4'd5, AM_DP,   OP_WORD_SUBTRACT};
      8'h5d: d = '{1'b1, 2'd2, 4'd4, AM_DP,   OP_WORD_COMPARE};
      8'hbd: d = '{1'b1, 2'd2, 4'd6, AM_DP,   OP_WORD_DECREMENT};
      8'h9d: d = '{1'b1, 2'd2, 4'd6, AM_DP,   OP_WORD_INCREMENT};
      8'h7d: d = '{1'b1, 2'd2, 4'd5, AM_DP,   OP_WORD_LOAD_PAIR};
      8'hdd: d = '{1'b1, 2'd2, 4'd5, AM_DP,   OP_WORD_STORE_PAIR};
      default: d = '0;
    endcase
    return d;
  endfunction : cdm_decode

  function automatic logic [7:0] cdm_nz8(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] r;
    r = p;
    r[PSW_N] = v[7];
    r[PSW_Z] = (v == 8'h00);
    return r;
  endfunction : cdm_nz8

  function automatic logic [7:0] cdm_nz16(input logic [7:0] p, input logic [15:0] v);
    logic [7:0] r;
    r = p;
    r[PSW_N] = v[15];
    r[PSW_Z] = (v == 16'h0000);
    return r;
  endfunction : cdm_nz16

  // Byte after a direct page address, staying inside the same page.
  function automatic logic [15:0] cdm_next(input logic [15:0] ad);
    return {ad[15:8], 8'(ad[7:0] + 8'h01)};
  endfunction : cdm_next

  // Commits a byte fetched for a load or an exchange.
  function automatic cdm_state_t cdm_load(input cdm_state_t st, input logic [7:0] v);
    cdm_state_t r;
    r = st;
    case (st.dec.op)
      OP_LDX:  r.x = v;
      OP_LDY:  r.y = v;
      default: r.a = v;
    endcase
    r.psw = cdm_nz8(st.psw, v);
    return r;
  endfunction : cdm_load

  // Forms the effective address once the operand bytes are in.
  function automatic cdm_state_t cdm_dispatch(input cdm_state_t st);
    cdm_state_t r;
    logic [7:0] pg;
    r  = st;
    pg = {7'h00, st.psw[PSW_G]};
    case (st.dec.mode)
      AM_DPX:  r.ea = {pg, 8'(st.op1 + st.x)};
      AM_DPY:  r.ea = {pg, 8'(st.op1 + st.y)};
      AM_ABS:  r.ea = {st.op2, st.op1};
      AM_ABSY: r.ea = 16'({st.op2, st.op1} + {8'h00, st.y});
      AM_IDX:  r.ea = {pg, 8'(st.op1 + st.x)};
      AM_XIND: r.ea = {pg, st.x};
      AM_XINC: r.ea = {pg, st.x};
      default: r.ea = {pg, st.op1};
    endcase
    if (st.dec.mode == AM_NONE) begin
      r.phase = PH_EXEC;
    end else if (st.dec.mode == AM_IDX || st.dec.mode == AM_IDY) begin
      r.phase = PH_PTRLO;
    end else if (st.dec.op == OP_STA || st.dec.op == OP_STX || st.dec.op == OP_STY ||
                 st.dec.op == OP_STM || st.dec.op == OP_WORD_STORE_PAIR) begin
      r.phase = PH_WRITE1;
    end else begin
      r.phase = PH_READ1;
    end
    return r;
  endfunction : cdm_dispatch

  always_comb begin
    case (s.phase)
      PH_PTRLO: rd_addr = s.ea;
      PH_PTRHI: rd_addr = cdm_next(s.ea);
      PH_READ1: rd_addr = s.ea;
      PH_READ2: rd_addr = cdm_next(s.ea);
      default:  rd_addr = s.pc;
    endcase
  end

  assign rd_byte   = mem[rd_addr[MEM_AW-1:0]];
  assign host_byte = mem[s.maddr[MEM_AW-1:0]];

  always_comb begin
    logic        fin;
    logic        idle;
    logic [15:0] ya;
    logic [15:0] m;
    logic [16:0] wide;
    logic [12:0] half;
    cdm_dec_t    d;
    fin    = 1'b0;
    idle   = (s.phase == PH_FETCH) && (!s.run || s.halted);
    ya     = {s.y, s.a};
    m      = {rd_byte, s.tmp};
    wide   = '0;
    half   = '0;
    d      = '0;
    mem_wr = '0;
    next_s = s;
    next_s.cnt = 4'(s.cnt + 4'h1);
    case (s.phase)
      PH_FETCH: begin
        next_s.cnt = 4'h0;
        if (s.run && !s.halted) begin
          d = cdm_decode(rd_byte);
          if (!d.valid) begin
            // Opcodes outside this block stop the core rather than guess.
            next_s.halted = 1'b1;
          end else begin
            next_s.dec = d;
            next_s.pc  = 16'(s.pc + 16'h0001);
            next_s.cnt = 4'h1;
            if (d.bytes > 2'd1) begin
              next_s.phase = PH_OPND1;
            end else begin
              next_s = cdm_dispatch(next_s);
            end
          end
        end
      end
      PH_OPND1: begin
        next_s.op1 = rd_byte;
        next_s.pc  = 16'(s.pc + 16'h0001);
        if (s.dec.bytes > 2'd2) begin
          next_s.phase = PH_OPND2;
        end else if (s.dec.mode == AM_IMM) begin
          next_s = cdm_load(next_s, rd_byte);
          fin    = 1'b1;
        end else begin
          next_s = cdm_dispatch(next_s);
        end
      end
      PH_OPND2: begin
        next_s.op2 = rd_byte;
        next_s.pc  = 16'(s.pc + 16'h0001);
        next_s     = cdm_dispatch(next_s);
      end
      PH_PTRLO: begin
        next_s.tmp   = rd_byte;
        next_s.phase = PH_PTRHI;
      end
      PH_PTRHI: begin
        next_s.ea  = (s.dec.mode == AM_IDY) ? 16'({rd_byte, s.tmp} + {8'h00, s.y})
                                            : {rd_byte, s.tmp};
        next_s.phase = (s.dec.op == OP_STA) ? PH_WRITE1 : PH_READ1;
      end
      PH_READ1: begin
        case (s.dec.op)
          OP_WORD_ADD, OP_WORD_SUBTRACT, OP_WORD_COMPARE, OP_WORD_DECREMENT, OP_WORD_INCREMENT, OP_WORD_LOAD_PAIR: begin
            next_s.tmp   = rd_byte;
            next_s.phase = PH_READ2;
          end
          OP_XMA: begin
            next_s.tmp   = s.a;
            next_s       = cdm_load(next_s, rd_byte);
            next_s.phase = PH_WRITE1;
          end
          default: begin
            next_s = cdm_load(next_s, rd_byte);
            if (s.dec.mode == AM_XINC) begin
              next_s.x = 8'(s.x + 8'h01);
            end
            fin = 1'b1;
          end
        endcase
      end
      PH_READ2: begin
        fin = 1'b1;
        case (s.dec.op)
          OP_WORD_ADD: begin
            wide = 17'({1'b0, ya} + {1'b0, m});
            half = 13'({1'b0, ya[11:0]} + {1'b0, m[11:0]});
            {next_s.y, next_s.a} = wide[15:0];
            next_s.psw = cdm_nz16(s.psw, wide[15:0]);
            next_s.psw[PSW_C] = wide[16];
            next_s.psw[PSW_H] = half[12];
            next_s.psw[PSW_V] = (ya[15] == m[15]) && (wide[15] != ya[15]);
          end
          OP_WORD_SUBTRACT, OP_WORD_COMPARE: begin
            wide = 17'({1'b0, ya} - {1'b0, m});
            next_s.psw = cdm_nz16(s.psw, wide[15:0]);
            next_s.psw[PSW_C] = ~wide[16];
            if (s.dec.op == OP_WORD_SUBTRACT) begin
              {next_s.y, next_s.a} = wide[15:0];
              next_s.psw[PSW_H] = (ya[11:0] >= m[11:0]);
              next_s.psw[PSW_V] = (ya[15] != m[15]) && (wide[15] != ya[15]);
            end
          end
          OP_WORD_LOAD_PAIR: begin
            next_s.a   = s.tmp;
            next_s.y   = rd_byte;
            next_s.psw = cdm_nz16(s.psw, m);
          end
          default: begin
            // The pair is written back in the next two cycles.
            next_s.wres  = (s.dec.op == OP_WORD_INCREMENT) ? 16'(m + 16'h0001)
                                                 : 16'(m - 16'h0001);
            next_s.psw   = cdm_nz16(s.psw, next_s.wres);
            next_s.phase = PH_WRITE1;
            fin          = 1'b0;
          end
        endcase
      end
      PH_WRITE1: begin
        mem_wr.en   = 1'b1;
        mem_wr.addr = s.ea;
        case (s.dec.op)
          OP_STX:           mem_wr.data = s.x;
          OP_STY:           mem_wr.data = s.y;
          OP_STM:           mem_wr.data = s.op2;
          OP_XMA:           mem_wr.data = s.tmp;
          OP_WORD_INCREMENT, OP_WORD_DECREMENT: mem_wr.data = s.wres[7:0];
          default:          mem_wr.data = s.a;
        endcase
        if (s.dec.mode == AM_XINC) begin
          next_s.x = 8'(s.x + 8'h01);
        end
        if (s.dec.op == OP_WORD_STORE_PAIR || s.dec.op == OP_WORD_INCREMENT || s.dec.op == OP_WORD_DECREMENT) begin
          next_s.phase = PH_WRITE2;
        end else begin
          fin = 1'b1;
        end
      end
      PH_WRITE2: begin
        mem_wr.en   = 1'b1;
        mem_wr.addr = cdm_next(s.ea);
        mem_wr.data = (s.dec.op == OP_WORD_STORE_PAIR) ? s.y : s.wres[15:8];
        fin         = 1'b1;
      end
      PH_EXEC: begin
        fin = 1'b1;
        case (s.dec.op)
          OP_TAX:  begin next_s.x = s.a; next_s.psw = cdm_nz8(s.psw, s.a); end
          OP_TAY:  begin next_s.y = s.a; next_s.psw = cdm_nz8(s.psw, s.a); end
          OP_COPY_STACKPTR_TO_X: begin next_s.x = s.sp; next_s.psw = cdm_nz8(s.psw, s.sp); end
          OP_COPY_X_TO_STACKPTR: begin next_s.sp = s.x; next_s.psw = cdm_nz8(s.psw, s.x); end
          OP_TXA:  begin next_s.a = s.x; next_s.psw = cdm_nz8(s.psw, s.x); end
          OP_TYA:  begin next_s.a = s.y; next_s.psw = cdm_nz8(s.psw, s.y); end
          OP_XAX:  begin next_s.a = s.x; next_s.x = s.a; end
          OP_XAY:  begin next_s.a = s.y; next_s.y = s.a; end
          default: begin next_s.x = s.y; next_s.y = s.x; end
        endcase
      end
      default: begin
        fin = 1'b1;
      end
    endcase
    // Work finishes early where it can; the pad holds the fixed cycle count.
    if (fin) begin
      next_s.phase = (next_s.cnt >= s.dec.cycles) ? PH_FETCH : PH_PAD;
    end

    // Host writes other than CTRL and MADDR only land between instructions while stopped or halted.
    next_s.rdata = 16'h0000;
    if (reg_req.wr) begin
      if (reg_req.addr == REG_CTRL) begin
        next_s.run = reg_req.wdata[CTRL_RUN_BIT];
      end else if (reg_req.addr == REG_MADDR) begin
        next_s.maddr = reg_req.wdata;
      end else if (idle && reg_req.addr == REG_PC) begin
        next_s.pc     = reg_req.wdata;
        next_s.halted = 1'b0;
      end else if (idle && reg_req.addr == REG_ACC) begin
        next_s.a = reg_req.wdata[7:0];
      end else if (idle && reg_req.addr == REG_X) begin
        next_s.x = reg_req.wdata[7:0];
      end else if (idle && reg_req.addr == REG_Y) begin
        next_s.y = reg_req.wdata[7:0];
      end else if (idle && reg_req.addr == REG_SP) begin
        next_s.sp = reg_req.wdata[7:0];
      end else if (idle && reg_req.addr == REG_PSW) begin
        next_s.psw = reg_req.wdata[7:0];
      end else if (idle && reg_req.addr == REG_MDATA) begin
        mem_wr.en    = 1'b1;
        mem_wr.addr  = s.maddr;
        mem_wr.data  = reg_req.wdata[7:0];
        next_s.maddr = 16'(s.maddr + 16'h0001);
      end
    end else if (reg_req.rd) begin
      if (reg_req.addr == REG_CTRL) begin
        next_s.rdata[CTRL_RUN_BIT] = s.run;
      end else if (reg_req.addr == REG_STATUS) begin
        next_s.rdata[STAT_HALT_BIT] = s.halted;
        next_s.rdata[STAT_BUSY_BIT] = (s.phase != PH_FETCH);
      end else if (reg_req.addr == REG_PC) begin
        next_s.rdata = s.pc;
      end else if (reg_req.addr == REG_ACC) begin
        next_s.rdata = {8'h00, s.a};
      end else if (reg_req.addr == REG_X) begin
        next_s.rdata = {8'h00, s.x};
      end else if (reg_req.addr == REG_Y) begin
        next_s.rdata = {8'h00, s.y};
      end else if (reg_req.addr == REG_SP) begin
        next_s.rdata = {8'h00, s.sp};
      end else if (reg_req.addr == REG_PSW) begin
        next_s.rdata = {8'h00, s.psw};
      end else if (reg_req.addr == REG_MADDR) begin
        next_s.rdata = s.maddr;
      end else if (reg_req.addr == REG_MDATA) begin
        next_s.rdata = {8'h00, host_byte};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s     <= '0;
      s.pc  <= RST_PC;
      s.sp  <= RST_SP;
      s.psw <= RST_PSW;
    end else begin
      s <= next_s;
    end
  end

  // The array holds no reset; software loads it before setting run.
  always_ff @(posedge ref_clk) begin
    if (mem_wr.en) begin
      mem[mem_wr.addr[MEM_AW-1:0]] <= mem_wr.data;
    end
  end

  assign reg_rdata   = s.rdata;
  assign core_halted = s.halted;

endmodule : cdm_core

//--- test/cdm_core_checker.sv
// Purpose: Port-level assertions for the data-move and word-op core.
// Assumes: One clock domain, reset_n active low.
// Notes:   Sees only the register port and the halt flag.
`timescale 1ns/1ps
module cdm_core_checker
  import cdm_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         reset_n,
  input wire cdm_reg_req_t reg_req,
  input wire logic [15:0]  reg_rdata,
  input wire logic         core_halted
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(logic [7:0] a);
    reg_req.rd && !reg_req.wr && reg_req.addr == a;
  endsequence
  sequence s_pc_wr;
    reg_req.wr && reg_req.addr == REG_PC;
  endsequence
  property p_idle_zero;
    !reg_req.rd |=> reg_rdata == 16'h0000;
  endproperty
  property p_acc_byte;
    s_rd(REG_ACC) |=> reg_rdata[15:8] == 8'h00;
  endproperty
  property p_x_byte;
    s_rd(REG_X) |=> reg_rdata[15:8] == 8'h00;
  endproperty
  property p_y_byte;
    s_rd(REG_Y) |=> reg_rdata[15:8] == 8'h00;
  endproperty
  property p_sp_byte;
    s_rd(REG_SP) |=> reg_rdata[15:8] == 8'h00;
  endproperty
  property p_mdata_byte;
    s_rd(REG_MDATA) |=> reg_rdata[15:8] == 8'h00;
  endproperty
  property p_status;
    s_rd(REG_STATUS) |=> reg_rdata[STAT_HALT_BIT] == $past(core_halted);
  endproperty
  property p_halt_hold;
    core_halted && !reg_req.wr |=> core_halted;
  endproperty
  property p_halt_clr;
    core_halted ##0 s_pc_wr |=> !core_halted;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("stray read data");
  a_acc_byte: assert property (p_acc_byte) else $error("acc upper byte set");
  a_x_byte: assert property (p_x_byte) else $error("x upper byte set");
  a_y_byte: assert property (p_y_byte) else $error("y upper byte set");
  a_sp_byte: assert property (p_sp_byte) else $error("sp upper byte set");
  a_mdata_byte: assert property (p_mdata_byte) else $error("mdata upper set");
  a_status: assert property (p_status) else $error("status halt bit wrong");
  a_halt_hold: assert property (p_halt_hold) else $error("halt dropped");
  a_halt_clr: assert property (p_halt_clr) else $error("halt not cleared");
endmodule : cdm_core_checker

//--- test/cdm_host.sv
// Purpose: Software-side master of the register port.
// Assumes: Strobes last one cycle and change just after a rising edge.
// Notes:   Read data is taken at the falling edge of the answer cycle.
`timescale 1ns/1ps
module cdm_host
  import cdm_pkg::*;
(
  input  wire logic        ref_clk,
  output cdm_reg_req_t     reg_req,
  input  wire logic [15:0] reg_rdata
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
endmodule : cdm_host

//--- test/cdm_core_tb.sv
// Purpose: Runs every instruction of the block once at random, once at a corner.
// Assumes: Opcode 8'hff halts the core, so it marks the program end.
// Notes:   Cycle counts are taken relative to a halt-only baseline run.
`timescale 1ns/1ps
module cdm_core_tb;
  import cdm_pkg::*;
  logic         ref_clk;
  logic         reset_n;
  cdm_reg_req_t reg_req;
  logic [15:0]  reg_rdata;
  logic         core_halted;
  int           errors;
  int           num_checks;
  logic [7:0]   m [0:127];
  logic [7:0]   a0, x0, y0, p0, sp0, b2, ea, ex, ey, ep, e40, e41;
  logic [15:0]  tbl [51] = '{16'hc422, 16'hc523, 16'hc624, 16'hc734, 16'hd535, 16'hd626,
    16'hd726, 16'hd413, 16'hdb14, 16'he435, 16'h1e22, 16'hcc23, 16'hcd24, 16'hdc34, 16'h3e22,
    16'hc923, 16'hd924, 16'hd834, 16'he524, 16'he625, 16'he735, 16'hf536, 16'hf627, 16'hf727,
    16'hf414, 16'hfb14, 16'hec24, 16'hed25, 16'hfc35, 16'he924, 16'hf925, 16'hf835, 16'he812,
    16'h9f12, 16'hae12, 16'hc812, 16'h8e12, 16'hbf12, 16'hee14, 16'hde14, 16'hbc25, 16'had26,
    16'hbb15, 16'hfe14, 16'h1d25, 16'h5d24, 16'hbd26, 16'h9d26, 16'h7d25, 16'hdd25, 16'h3d25};
  cdm_core dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .core_halted(core_halted));
  cdm_host hst (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [7:0] op);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: op %h got %h want %h", $time, op, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [15:0] exp, input logic [7:0] op);
    logic [15:0] d;
    hst.rd(a, d);
    chk(d, exp, op);
  endtask : rc
  task automatic test_done;
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic rnd(input int pass);
    for (int i = 0; i < 128; i++) begin
      m[i] = 8'($urandom);
      if (i > 'h40) m[i][0] = 1'b1;
    end
    // Odd high pointer bytes keep indirect stores away from the program bytes.
    if (pass == 1) {m['h41], m['h40]} = 16'hffff;
    a0 = pass == 1 ? 8'h00 : 8'($urandom);
    x0 = 8'h20 | 8'($urandom & 'h1f);
    y0 = 8'h20 | 8'($urandom & 'h1f);
    p0 = 8'($urandom) & 8'hcb;
    sp0 = 8'($urandom);
    b2 = 8'($urandom);
  endtask : rnd
  task automatic run(input logic [7:0] op, input int len, output int n);
    hst.wr(REG_CTRL, 16'h0000);
    hst.wr(REG_PC, 16'h0000);
    hst.wr(REG_ACC, {8'h00, a0});
    hst.wr(REG_X, {8'h00, x0});
    hst.wr(REG_Y, {8'h00, y0});
    hst.wr(REG_SP, {8'h00, sp0});
    hst.wr(REG_PSW, {8'h00, p0});
    m[0] = op;
    m[1] = 8'h40;
    m[2] = b2;
    m[len] = 8'hff;
    hst.wr(REG_MADDR, 16'h0000);
    for (int i = 0; i < 128; i++) hst.wr(REG_MDATA, {8'h00, m[i]});
    hst.wr(REG_CTRL, 16'h0001);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (core_halted !== 1'b1 && n < 300);
    hst.wr(REG_CTRL, 16'h0000);
  endtask : run
  function automatic logic [7:0] nz(input logic n, input logic z);
    nz = {n, p0[6:2], z, p0[0]};
  endfunction : nz
  function automatic bit model(input logic [7:0] op);
    logic [16:0] s;
    logic [12:0] h;
    logic [15:0] w;
    {ea, ex, ey, ep, e40, e41} = {a0, x0, y0, p0, m['h40], m['h41]};
    model = 1'b1;
    case (op)
      8'hc4, 8'h1e: begin
        {ea, ex} = op[7] ? {8'h40, x0} : {a0, 8'h40};
        ep = nz(1'b0, 1'b0);
      end
      8'hdb: {ea, ex, ep} = {m[x0], x0 + 8'h01, nz(m[x0][7], m[x0] == 0)};
      8'he8: {ex, ep} = {a0, nz(a0[7], a0 == 0)};
      8'hc5: {ea, ep} = {e40, nz(e40[7], e40 == 0)};
      8'hcc: {ex, ep} = {e40, nz(e40[7], e40 == 0)};
      8'hbc: {ea, e40, ep} = {e40, a0, nz(e40[7], e40 == 0)};
      8'h9f: {ey, ep} = {a0, nz(a0[7], a0 == 0)};
      8'hae: {ex, ep} = {sp0, nz(sp0[7], sp0 == 0)};
      8'hc8: {ea, ep} = {x0, nz(x0[7], x0 == 0)};
      8'hbf: {ea, ep} = {y0, nz(y0[7], y0 == 0)};
      8'hde: {ea, ey} = {y0, a0};
      8'hee: {ea, ex} = {x0, a0};
      8'hfe: {ex, ey} = {y0, x0};
      8'hfb: ex = x0 + 8'h01;
      8'he5: e40 = a0;
      8'hec: e40 = x0;
      8'he9: e40 = y0;
      8'he4: e40 = b2;
      8'hdd: {e41, e40} = {y0, a0};
      8'h7d: {ey, ea, ep} = {e41, e40, nz(e41[7], {e41, e40} == 0)};
      8'h9d, 8'hbd: begin
        {e41, e40} = {e41, e40} + (op[5] ? 16'hffff : 16'h0001);
        ep = nz(e41[7], {e41, e40} == 16'h0000);
      end
      8'h1d, 8'h3d, 8'h5d: begin
        // Subtract is add of the inverse plus one, so carry means no borrow.
        w = (op[6] | op[5]) ? ~{e41, e40} : {e41, e40};
        s = {1'b0, y0, a0} + {1'b0, w} + 17'(op[6] | op[5]);
        h = {1'b0, y0[3:0], a0} + {1'b0, w[11:0]} + 13'(op[6] | op[5]);
        {ey, ea} = op[6] ? {y0, a0} : s[15:0];
        ep = {s[15], y0[7] == w[15] && s[15] != y0[7], p0[5:4], h[12], p0[2], s[15:0] == 0, s[16]};
        // Compare leaves V and H alone.
        if (op[6]) {ep[6], ep[3]} = {p0[6], p0[3]};
      end
      default: model = 1'b0;
    endcase
  endfunction : model
  initial begin
    #6_000_000;
    errors++;
    test_done();
  end
  initial begin
    int n0;
    int n;
    logic [7:0] op;
    errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    void'($urandom(32'hd947));
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    rc(REG_SP, 16'h00ff, 8'h00);
    rc(REG_PSW, 16'h0000, 8'h00);
    rc(8'h28, 16'h0000, 8'h00);
    rnd(0);
    run(8'hff, 0, n0);
    for (int pass = 0; pass < 2; pass++) begin
      for (int k = 0; k < 51; k++) begin
        op = tbl[k][15:8];
        rnd(pass);
        run(op, int'(tbl[k][7:4]), n);
        chk(16'(n), 16'(n0) + 16'(tbl[k][3:0]), op);
        rc(REG_PC, 16'(tbl[k][7:4]), op);
        rc(REG_STATUS, 16'h0001, op);
        if (model(op)) begin
          rc(REG_ACC, {8'h00, ea}, op);
          rc(REG_X, {8'h00, ex}, op);
          rc(REG_Y, {8'h00, ey}, op);
          rc(REG_PSW, {8'h00, ep}, op);
          hst.wr(REG_MADDR, 16'h0040);
          rc(REG_MDATA, {8'h00, e40}, op);
          hst.wr(REG_MADDR, 16'h0041);
          rc(REG_MDATA, {8'h00, e41}, op);
        end
      end
    end
    test_done();
  end
endmodule : cdm_core_tb
bind cdm_core cdm_core_checker chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .core_halted(core_halted));
